// ### src/dmafa_channel.sv
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Summary of operation
// - Channel runs as one full-address channel when both select bits are 1.
// - Source word feeds read addresses, destination word feeds writes.
// - Address top byte ignores writes and reads back as zero.
// - Reset and standby leave addresses and counts untouched.
// - Fixed I/O address registers are not used in this mode.
// - Normal mode: count A drops per unit, transfer ends at zero.
// - Block mode: block counter drops per unit, reloads from low byte.
// - Block mode: count B drops per block, transfer ends at zero.
// - First control register clears on reset and on standby.
// - Enabled only with channel and master enable; otherwise requests ignored.
// - Auto-request starts at once; other sources wait for a request per unit, or per block in block mode.
// - Channel enable clears itself when all transfers are done.
// - Channel enable sets only after a read that saw it at zero.
// - With interrupt enable, end interrupt follows channel enable clearing.
// - Size bit picks byte or 16-bit word; resets to byte.
// - Source address holds, rises or falls by unit size.
// - Lowest control bit picks normal or block mode.
// - Non-maskable interrupt clears master enable; setting it resumes.
// - Destination address steps like source, from second control register.
// - Block area side chosen by mode-select bit: destination or source.
// - Request sources: auto burst, auto steal, pin falling edge, pin low.
// ----------------------------------------------------------------------
module dmafa_channel (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic standby_i,
    input wire logic nmi_i,
    input wire logic transfer_request_pin_n_i,
    input wire logic end_irq_ack_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output dmafa_pkg::dmafa_mem_cmd_s mem_cmd_o,
    input wire logic mem_ack_i,
    input wire logic [15:0] mem_rdata_i,
    output logic end_of_transfer_interrupt_o
);
    import dmafa_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] src_addr_r, src_addr_nxt;
    logic [ADDR_W-1:0] dst_addr_r, dst_addr_nxt;
    logic [ADDR_W-1:0] blk_base_r;
    logic [CNT_W-1:0] cnt_a_r, cnt_a_nxt;
    logic [CNT_W-1:0] cnt_b_r, cnt_b_nxt;
    logic [7:0] ctl1_r, ctl1_nxt;
    logic [7:0] ctl2_r, ctl2_nxt;
    logic arm1_r, arm2_r;
    logic in_block_r, pin_prev_r, edge_pend_r, en_prev_r, irq_r;
    logic dph_wr_r;
    logic [7:0] dph_addr_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    dmafa_state_e state_r, state_nxt;
    dmafa_mem_cmd_s mem_cmd_r, mem_cmd_nxt;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire logic ap_ok, ap_in_map, rd_ok;
    wire logic [7:0] ap_off;
    wire logic wr_src, wr_dst, wr_cnta, wr_cntb, wr_ctl1, wr_ctl2;
    wire logic [31:0] rd_val;

    // Only word offsets with zero upper address bits are mapped
    assign ap_ok = hsel_i & htrans_i[1] & hready_i;
    assign ap_in_map = (haddr_i[31:8] == 24'h00_0000);
    assign ap_off = haddr_i[7:0];
    assign rd_ok = ap_ok & ~hwrite_i & ap_in_map;
    assign wr_src = dph_wr_r & (dph_addr_r == OFS_SRC);
    assign wr_dst = dph_wr_r & (dph_addr_r == OFS_DST);
    assign wr_cnta = dph_wr_r & (dph_addr_r == OFS_CNTA);
    assign wr_cntb = dph_wr_r & (dph_addr_r == OFS_CNTB);
    assign wr_ctl1 = dph_wr_r & (dph_addr_r == OFS_CTL1);
    assign wr_ctl2 = dph_wr_r & (dph_addr_r == OFS_CTL2);

    // Reserved top byte reads as zero; unmapped reads as zero
    assign rd_val = !ap_in_map ? 32'h0000_0000 :
        (ap_off == OFS_SRC) ? {8'h00, src_addr_r} :
        (ap_off == OFS_DST) ? {8'h00, dst_addr_r} :
        (ap_off == OFS_CNTA) ? {16'h0000, cnt_a_r} :
        (ap_off == OFS_CNTB) ? {16'h0000, cnt_b_r} :
        (ap_off == OFS_CTL1) ? {24'h00_0000, ctl1_r} :
        (ap_off == OFS_CTL2) ? {24'h00_0000, ctl2_r} : 32'h0000_0000;

    // Address phase captured; writes land in the data phase
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            dph_wr_r <= 1'b0;
            dph_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
        end else begin
            dph_wr_r <= ap_ok & hwrite_i & ap_in_map;
            dph_addr_r <= ap_off;
            hrdata_r <= rd_ok ? rd_val : hrdata_r;
            hreadyout_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Mode, enable and request decode
    // ------------------------------------------------------------------
    wire logic full_mode, chan_on, blk_mode, word_sz, tms_src;
    wire logic [2:0] req_src;
    wire logic auto_req, pin_fall, req_now, start;

    assign full_mode = ctl1_r[CTL1_SEL2] & ctl1_r[CTL1_SEL1];
    assign chan_on = full_mode & ctl1_r[CTL1_EN] & ctl2_r[CTL2_MEN];
    assign blk_mode = ctl1_r[CTL1_BLK];
    assign word_sz = ctl1_r[CTL1_SZ];
    assign tms_src = ctl2_r[CTL2_TMS];
    assign req_src = ctl2_r[2:0];
    // Burst and steal behave alike: this port is the only bus master
    assign auto_req = (req_src == RS_AUTO_BURST) |
        (req_src == RS_AUTO_STEAL);
    assign pin_fall = pin_prev_r & ~transfer_request_pin_n_i;
    assign req_now = auto_req |
        ((req_src == RS_PIN_EDGE) & edge_pend_r) |
        ((req_src == RS_PIN_LEVEL) & ~transfer_request_pin_n_i);
    // A started block runs to its end without further requests
    assign start = (state_r == ST_IDLE) & chan_on & (in_block_r | req_now);

    // ------------------------------------------------------------------
    // Unit completion and counting
    // ------------------------------------------------------------------
    wire logic unit_done, blk_end, finish;
    wire logic [7:0] bsz_dec, bsz_new;
    wire logic [CNT_W-1:0] cnt_a_dec, cnt_b_dec;
    wire logic [ADDR_W-1:0] src_step, dst_step, src_upd, dst_upd;

    assign unit_done = (state_r == ST_WRITE) & mem_ack_i;
    assign cnt_a_dec = cnt_a_r - 16'h0001;
    assign cnt_b_dec = cnt_b_r - 16'h0001;
    assign bsz_dec = cnt_a_r[15:8] - 8'h01;
    assign blk_end = blk_mode & (bsz_dec == 8'h00);
    assign bsz_new = blk_end ? cnt_a_r[7:0] : bsz_dec;
    assign finish = unit_done & (blk_mode ?
        (blk_end & (cnt_b_dec == 16'h0000)) :
        (cnt_a_dec == 16'h0000));

    // Only the two address words drive the bus; no fixed I/O address
    dmafa_addr_step u_src_step (
        .addr_i(src_addr_r),
        .step_en_i(ctl1_r[CTL1_SSTEP]),
        .dir_down_i(ctl1_r[CTL1_SDIR]),
        .word_i(word_sz),
        .next_o(src_step)
    );

    dmafa_addr_step u_dst_step (
        .addr_i(dst_addr_r),
        .step_en_i(ctl2_r[CTL2_DSTEP]),
        .dir_down_i(ctl2_r[CTL2_DDIR]),
        .word_i(word_sz),
        .next_o(dst_step)
    );

    // Block area side returns to its start after each block
    assign src_upd = (blk_end & tms_src) ? blk_base_r : src_step;
    assign dst_upd = (blk_end & ~tms_src) ? blk_base_r : dst_step;

    // Software writes win over the hardware update in the same cycle
    assign src_addr_nxt = wr_src ? hwdata_i[ADDR_W-1:0] :
        (unit_done ? src_upd : src_addr_r);
    assign dst_addr_nxt = wr_dst ? hwdata_i[ADDR_W-1:0] :
        (unit_done ? dst_upd : dst_addr_r);
    assign cnt_a_nxt = wr_cnta ? hwdata_i[CNT_W-1:0] :
        (!unit_done ? cnt_a_r :
        (blk_mode ? {bsz_new, cnt_a_r[7:0]} : cnt_a_dec));
    assign cnt_b_nxt = wr_cntb ? hwdata_i[CNT_W-1:0] :
        ((unit_done & blk_end) ? cnt_b_dec : cnt_b_r);

    // Address and count words have no reset on purpose
    always_ff @(posedge core_clk_i) begin
        src_addr_r <= src_addr_nxt;
        dst_addr_r <= dst_addr_nxt;
        cnt_a_r <= cnt_a_nxt;
        cnt_b_r <= cnt_b_nxt;
        if (start & ~in_block_r) begin
            blk_base_r <= tms_src ? src_addr_r : dst_addr_r;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Enable bits set only when armed by a read; hardware clears win
    always_comb begin
        ctl1_nxt = ctl1_r;
        ctl2_nxt = ctl2_r;
        if (wr_ctl1) begin
            ctl1_nxt = hwdata_i[7:0];
            ctl1_nxt[CTL1_EN] = hwdata_i[CTL1_EN] &
                (ctl1_r[CTL1_EN] | arm1_r);
        end
        if (finish) begin
            ctl1_nxt[CTL1_EN] = 1'b0;
        end
        if (wr_ctl2) begin
            ctl2_nxt = hwdata_i[7:0];
            ctl2_nxt[CTL2_MEN] = hwdata_i[CTL2_MEN] &
                (ctl2_r[CTL2_MEN] | arm2_r);
        end
        if (nmi_i) begin
            ctl2_nxt[CTL2_MEN] = 1'b0;
        end
    end

    // Standby clears control like reset does
    always_ff @(posedge core_clk_i) begin
        if (srst_i | standby_i) begin
            ctl1_r <= CTL_RESET;
            ctl2_r <= CTL_RESET;
            arm1_r <= 1'b0;
            arm2_r <= 1'b0;
        end else begin
            ctl1_r <= ctl1_nxt;
            ctl2_r <= ctl2_nxt;
            // An arming read in a write's data phase still arms
            arm1_r <= (rd_ok & (ap_off == OFS_CTL1) & ~ctl1_r[CTL1_EN]) |
                (arm1_r & ~wr_ctl1);
            arm2_r <= (rd_ok & (ap_off == OFS_CTL2) & ~ctl2_r[CTL2_MEN]) |
                (arm2_r & ~wr_ctl2);
        end
    end

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    // A unit in flight completes unless reset or standby hits, so a suspend lands between units
    always_comb begin
        state_nxt = state_r;
        mem_cmd_nxt = mem_cmd_r;
        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    state_nxt = ST_READ;
                    mem_cmd_nxt.req = 1'b1;
                    mem_cmd_nxt.wr = 1'b0;
                    mem_cmd_nxt.word = word_sz;
                    mem_cmd_nxt.addr = src_addr_r;
                end
            end
            ST_READ: begin
                if (mem_ack_i) begin
                    state_nxt = ST_WRITE;
                    mem_cmd_nxt.wr = 1'b1;
                    mem_cmd_nxt.addr = dst_addr_r;
                    mem_cmd_nxt.wdata = mem_rdata_i;
                end
            end
            ST_WRITE: begin
                if (mem_ack_i) begin
                    state_nxt = ST_IDLE;
                    mem_cmd_nxt.req = 1'b0;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                mem_cmd_nxt.req = 1'b0;
            end
        endcase
    end

    // Sequencer, request edge latch and end interrupt
    always_ff @(posedge core_clk_i) begin
        if (srst_i | standby_i) begin
            state_r <= ST_IDLE;
            mem_cmd_r <= '0;
            in_block_r <= 1'b0;
            pin_prev_r <= 1'b1;
            edge_pend_r <= 1'b0;
            en_prev_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mem_cmd_r <= mem_cmd_nxt;
            in_block_r <= (start & blk_mode) |
                (in_block_r & ~(unit_done & blk_end));
            pin_prev_r <= transfer_request_pin_n_i;
            // Edges seen while disabled are dropped; new edge beats consume
            edge_pend_r <= chan_on & (req_src == RS_PIN_EDGE) &
                (pin_fall | (edge_pend_r & ~start));
            en_prev_r <= ctl1_r[CTL1_EN];
            irq_r <= (en_prev_r & ~ctl1_r[CTL1_EN] & ctl1_r[CTL1_IE]) |
                (irq_r & ~end_irq_ack_i);
        end
    end

    assign hrdata_o = hrdata_r;
    assign hreadyout_o = hreadyout_r;
    assign hresp_o = 1'b0;
    assign mem_cmd_o = mem_cmd_r;
    assign end_of_transfer_interrupt_o = irq_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_mode_gate: assert property (@(posedge core_clk_i)
        disable iff (srst_i | standby_i)
        (state_r == ST_IDLE) && !full_mode |=> state_r == ST_IDLE)
        else $error("transfer started outside full-address mode");

    a_read_source: assert property (@(posedge core_clk_i)
        disable iff (srst_i | standby_i)
        start |=> mem_cmd_r.req && !mem_cmd_r.wr &&
            mem_cmd_r.addr == $past(src_addr_r))
        else $error("read not issued at source address");

    a_top_byte_zero: assert property (@(posedge core_clk_i)
        disable iff (srst_i)
        rd_ok && (ap_off == OFS_SRC || ap_off == OFS_DST)
            |=> hrdata_o[31:24] == 8'h00)
        else $error("reserved address byte read back nonzero");

    a_count_normal: assert property (@(posedge core_clk_i)
        disable iff (srst_i)
        unit_done && !blk_mode && !wr_cnta
            |=> cnt_a_r == $past(cnt_a_r) - 16'h0001)
        else $error("normal count did not drop by one");

    a_block_reload: assert property (@(posedge core_clk_i)
        disable iff (srst_i)
        unit_done && blk_mode && !wr_cnta && cnt_a_r[15:8] == 8'h01
            |=> cnt_a_r[15:8] == $past(cnt_a_r[7:0]))
        else $error("block size counter not reloaded");

    a_block_count: assert property (@(posedge core_clk_i)
        disable iff (srst_i)
        unit_done && blk_end && !wr_cntb
            |=> cnt_b_r == $past(cnt_b_r) - 16'h0001)
        else $error("block count did not drop after a block");

    a_standby_clear: assert property (@(posedge core_clk_i)
        standby_i |=> ctl1_r == CTL_RESET)
        else $error("control not cleared by standby");

    a_disabled_idle: assert property (@(posedge core_clk_i)
        disable iff (srst_i | standby_i)
        (state_r == ST_IDLE) && !chan_on |=> state_r == ST_IDLE)
        else $error("transfer started while disabled");

    a_auto_start: assert property (@(posedge core_clk_i)
        disable iff (srst_i | standby_i)
        (state_r == ST_IDLE) && chan_on && auto_req
            |=> state_r == ST_READ)
        else $error("auto-request did not start at once");

    a_finish_clear: assert property (@(posedge core_clk_i)
        disable iff (srst_i | standby_i)
        finish |=> !ctl1_r[CTL1_EN] ##1 !chan_on)
        else $error("enable not cleared at completion");

    a_enable_guard: assert property (@(posedge core_clk_i)
        disable iff (srst_i | standby_i)
        wr_ctl1 && !ctl1_r[CTL1_EN] && !arm1_r |=> !ctl1_r[CTL1_EN])
        else $error("enable set without preceding read");

    a_irq_raise: assert property (@(posedge core_clk_i)
        disable iff (srst_i | standby_i)
        $fell(ctl1_r[CTL1_EN]) && ctl1_r[CTL1_IE]
            |=> end_of_transfer_interrupt_o)
        else $error("end interrupt missing after enable fell");

    a_irq_hold: assert property (@(posedge core_clk_i)
        disable iff (srst_i | standby_i)
        end_of_transfer_interrupt_o && !end_irq_ack_i
            |=> end_of_transfer_interrupt_o)
        else $error("end interrupt dropped before acknowledge");

    a_nmi_stop: assert property (@(posedge core_clk_i)
        disable iff (srst_i | standby_i)
        nmi_i |=> !ctl2_r[CTL2_MEN] && !chan_on)
        else $error("master enable kept after nmi");

endmodule

// ### src/dmafa_pkg.sv
// ----------------------------------------------------------------------
// Register map and field layout
// ----------------------------------------------------------------------
package dmafa_pkg;

    // Byte offsets on the register bus
    localparam logic [7:0] OFS_SRC = 8'h00;
    localparam logic [7:0] OFS_DST = 8'h04;
    localparam logic [7:0] OFS_CNTA = 8'h08;
    localparam logic [7:0] OFS_CNTB = 8'h0C;
    localparam logic [7:0] OFS_CTL1 = 8'h10;
    localparam logic [7:0] OFS_CTL2 = 8'h14;

    // Stored address width; the top byte of each word is reserved
    localparam int ADDR_W = 24;
    localparam int CNT_W = 16;

    // First control register fields
    localparam int CTL1_EN = 7;
    localparam int CTL1_SZ = 6;
    localparam int CTL1_SDIR = 5;
    localparam int CTL1_SSTEP = 4;
    localparam int CTL1_IE = 3;
    localparam int CTL1_SEL2 = 2;
    localparam int CTL1_SEL1 = 1;
    localparam int CTL1_BLK = 0;

    // Second control register fields
    localparam int CTL2_MEN = 7;
    localparam int CTL2_DDIR = 5;
    localparam int CTL2_DSTEP = 4;
    localparam int CTL2_TMS = 3;

    localparam logic [7:0] CTL_RESET = 8'h00;

    // Request source codes, second control register bits 2..0
    localparam logic [2:0] RS_AUTO_BURST = 3'h0;
    localparam logic [2:0] RS_AUTO_STEAL = 3'h2;
    localparam logic [2:0] RS_PIN_EDGE = 3'h6;
    localparam logic [2:0] RS_PIN_LEVEL = 3'h7;

    // Address step per unit
    localparam logic [1:0] STEP_BYTE = 2'h1;
    localparam logic [1:0] STEP_WORD = 2'h2;

    // Gray coded along idle, read, write
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WRITE = 2'b11
    } dmafa_state_e;

    // One memory access towards the internal bus
    typedef struct packed {
        logic req;
        logic wr;
        logic word;
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
    } dmafa_mem_cmd_s;

endpackage

// ### src/dmafa_addr_step.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Address stepper: hold, increment or decrement by unit size
// ----------------------------------------------------------------------
module dmafa_addr_step #(
    parameter int unsigned ADDR_BITS = dmafa_pkg::ADDR_W
) (
    input wire logic [ADDR_BITS-1:0] addr_i,
    input wire logic step_en_i,
    input wire logic dir_down_i,
    input wire logic word_i,
    output logic [ADDR_BITS-1:0] next_o
);
    import dmafa_pkg::*;

    // A one-bit address could not hold a word step
    if (ADDR_BITS < 2) begin : g_bad_width
        $error("dmafa_addr_step: ADDR_BITS must be at least 2");
    end

    // Step size widened to the address width
    wire logic [ADDR_BITS-1:0] delta;
    wire logic [ADDR_BITS-1:0] up_val;
    wire logic [ADDR_BITS-1:0] down_val;

    // Direction only matters while stepping is enabled
    assign delta = ADDR_BITS'(word_i ? STEP_WORD : STEP_BYTE);
    assign up_val = addr_i + delta;
    assign down_val = addr_i - delta;
    assign next_o = !step_en_i ? addr_i : (dir_down_i ? down_val : up_val);

endmodule

// ### sim/dmafa_mem_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Memory partner: acks each held command after 0..3 idle cycles
// ----------------------------------------------------------------------
module dmafa_mem_model (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire dmafa_pkg::dmafa_mem_cmd_s cmd_i,
    output logic ack_o,
    output logic [15:0] rdata_o,
    output logic [31:0] n_wr_o,
    output logic [23:0] last_addr_o,
    output logic [15:0] last_data_o
);
    import dmafa_pkg::*;
    int wait_r;
    // Data lines toggle when not acked, so stale reads never look valid
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ack_o <= 1'b0;
            wait_r <= 0;
            n_wr_o <= 0;
            rdata_o <= 16'h0000;
        end else begin
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o;
            if (cmd_i.req && !ack_o) begin
                if (wait_r == 0) begin
                    ack_o <= 1'b1;
                    rdata_o <= cmd_i.addr[15:0] ^ 16'hA5C3;
                    wait_r <= $urandom_range(3);
                    if (cmd_i.wr) begin
                        n_wr_o <= n_wr_o + 1;
                        last_addr_o <= cmd_i.addr;
                        last_data_o <= cmd_i.wdata;
                    end
                end else begin
                    wait_r <= wait_r - 1;
                end
            end
        end
    end
endmodule

// ### sim/dmafa_channel_test.sv
`timescale 1ns/100ps
module dmafa_channel_test;
    import dmafa_pkg::*;
    logic clk = 0, srst = 1, stby = 0, nmi = 0, pin_n = 1, iack = 0;
    logic hsel = 0, hwrite = 0, hready, hresp, irq, mack;
    logic [1:0] htrans = 0, ss, ds;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q, n_wr;
    logic [23:0] src, dst, la, sd, es;
    logic [15:0] rdat, ld;
    logic [7:0] c1;
    logic [2:0] rs[4] = '{RS_AUTO_BURST, RS_AUTO_STEAL, RS_PIN_EDGE,
        RS_PIN_LEVEL};
    logic sz, ie, blk, tms;
    dmafa_mem_cmd_s cmd;
    int n_fail = 0, checks = 0, cyc = 0, n, bs, nb, w0, w1, ns, nd;
    dmafa_channel dmafa_channel_inst (.core_clk_i(clk), .srst_i(srst),
        .standby_i(stby), .nmi_i(nmi), .transfer_request_pin_n_i(pin_n),
        .end_irq_ack_i(iack), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .mem_cmd_o(cmd),
        .mem_ack_i(mack), .mem_rdata_i(rdat),
        .end_of_transfer_interrupt_o(irq));
    dmafa_mem_model dmafa_mem_model_inst (.core_clk_i(clk), .srst_i(srst),
        .cmd_i(cmd), .ack_o(mack), .rdata_o(rdat), .n_wr_o(n_wr),
        .last_addr_o(la), .last_data_o(ld));
    // ------------------------------------------------------------------
    // Clock, request pin noise, hang guard
    // ------------------------------------------------------------------
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        pin_n <= 1'($urandom);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            wrap_up();
        end
    end
    // Step per unit for {direction, enable}
    function automatic logic [23:0] delta(logic [1:0] de, logic w);
        return de[0] ? (de[1] ? -24'(w + 1) : 24'(w + 1)) : 24'h00_0000;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Single AHB transfer; read data lands in q at the data phase edge
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(81));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        bus(0, OFS_CTL1, 0);
        chk(q, 0);
        bus(0, 8'h20, 0);
        chk(q | 32'(hresp), 0);
        bus(1, OFS_SRC, 32'hFF12_3456);
        bus(0, OFS_SRC, 0);
        chk(q, 32'h0012_3456);
        bus(1, OFS_CTL1, 8'h06);
        bus(1, OFS_CTL1, 8'h86);
        bus(0, OFS_CTL1, 0);
        chk(q, 8'h06);
        for (int i = 0; i < 8; i++) begin
            {sz, ie, ss, ds} = 6'($urandom);
            blk = i[0];
            src = 24'($urandom);
            dst = 24'($urandom);
            bs = 1 + $urandom % 3;
            nb = 1 + $urandom % 2;
            n = blk ? bs * nb : (i == 2 ? 6 : 1 + $urandom % 5);
            // Block side alternates so both areas get restored
            tms = blk & i[1];
            ns = (blk && tms) ? bs : n;
            nd = (blk && !tms) ? bs : n;
            bus(1, OFS_SRC, 32'(src));
            bus(1, OFS_DST, 32'(dst));
            bus(1, OFS_CNTA, blk ? {bs[7:0], bs[7:0]} : n);
            bus(1, OFS_CNTB, nb);
            bus(0, OFS_CTL2, 0);
            bus(1, OFS_CTL2, {2'b10, ds, tms, rs[i % 4]});
            c1 = {1'b1, sz, ss, ie, 2'b11, blk};
            w0 = n_wr;
            bus(0, OFS_CTL1, 0);
            chk(n_wr, w0);
            bus(1, OFS_CTL1, c1);
            if (i == 2) begin
                @(posedge clk) nmi <= 1'b1;
                @(posedge clk) nmi <= 1'b0;
                repeat (20) @(posedge clk);
                w1 = n_wr;
                repeat (20) @(posedge clk);
                chk(n_wr, w1);
                bus(0, OFS_CTL2, 0);
                bus(1, OFS_CTL2, {2'b10, ds, tms, rs[2]});
            end
            while (n_wr - w0 != n) @(posedge clk);
            repeat (4) @(posedge clk);
            chk(irq, ie);
            @(posedge clk) iack <= 1'b1;
            @(posedge clk) iack <= 1'b0;
            @(posedge clk);
            chk(irq, 0);
            bus(0, OFS_CTL1, 0);
            chk(q, c1 & 8'h7F);
            bus(0, OFS_CNTA, 0);
            chk(q, blk ? {bs[7:0], bs[7:0]} : 0);
            bus(0, OFS_CNTB, 0);
            chk(q, blk ? 0 : nb);
            sd = delta(ss, sz);
            es = (blk && tms) ? src : 24'(src + sd * n);
            chk(la, 24'(dst + (nd - 1) * delta(ds, sz)));
            chk(ld & (sz ? 16'hFFFF : 16'h00FF),
                (sz ? 16'hFFFF : 16'h00FF)
                & ((src[15:0] + 16'(sd * (ns - 1))) ^ 16'hA5C3));
            bus(0, OFS_SRC, 0);
            chk(q, 32'(es));
        end
        @(posedge clk) stby <= 1'b1;
        @(posedge clk) stby <= 1'b0;
        bus(0, OFS_CTL1, 0);
        chk(q, 0);
        // Reset with the channel idle after standby must leave the address words alone
        @(posedge clk) srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        bus(0, OFS_SRC, 0);
        chk(q, 32'(es));
        wrap_up();
    end
endmodule
